/* File: pkg/ssfv_pkg.sv */
/*
  constants, register indices and carrier structs for the servo drive
  status and fault variable bank.
  assumes one 100 MHz clock and a word-indexed register port.
*/
package ssfv_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int VEL_PERIOD_US = 26210;
  localparam int VEL_CYCLES = VEL_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int VEL_CNT_W = 22;

  localparam logic [4:0] REG_EXT_FAULT = 5'h00;
  localparam logic [4:0] REG_FAULT_CODE = 5'h01;
  localparam logic [4:0] REG_STATUS = 5'h02;
  localparam logic [4:0] REG_INPUTS = 5'h03;
  localparam logic [4:0] REG_SWITCHES = 5'h04;
  localparam logic [4:0] REG_FB_FAULT = 5'h05;
  localparam logic [4:0] REG_ANGLE = 5'h06;
  localparam logic [4:0] REG_TURNS = 5'h07;
  localparam logic [4:0] REG_RAW_VEL = 5'h08;
  localparam logic [4:0] REG_FILT_VEL = 5'h09;
  localparam logic [4:0] REG_HS_TEMP = 5'h0a;
  localparam logic [4:0] REG_HS_TRIP = 5'h0b;
  localparam logic [4:0] REG_IDENT = 5'h0c;
  localparam logic [4:0] REG_LW_VERSION = 5'h0d;
  localparam logic [4:0] REG_SW_ENABLE = 5'h0e;
  localparam logic [4:0] REG_FAULT_CLEAR = 5'h0f;
  localparam logic [4:0] REG_STEP_COUNT = 5'h10;

  localparam logic SW_ENABLE_RST = 1'b1;
  localparam logic [15:0] EXT_FAULT_RST = 16'h0000;
  localparam logic [4:0] FAULT_CODE_RST = 5'h00;
  localparam logic [4:0] FAULT_CODE_DRIVE_TEMP = 5'h03;
  localparam int EXT_BIT_OVER_TEMP = 7;

  // identity values below are arbitrary
  localparam logic [3:0] LOGIC_HW_REV = 4'h1;
  localparam logic [23:0] LW_VERSION = 24'h01_0001;
  localparam logic [31:0] VALID_MODEL_MASK = 32'h0000_00fe;

  // heat sink values in tenths of a degree C, signed
  localparam logic [15:0] HS_TRIP_RST = 16'h0560;

  // motor current is a fraction of peak in 1/65536 units
  localparam logic [15:0] CUR_HI_TH = 16'(53 * 65536 / 100);
  localparam logic [15:0] CUR_LO_TH = 16'((32 * 65536 + 99) / 100);
  // commutation frequency in hundredths of a hertz
  localparam logic [15:0] FREQ_LO_TH = 16'h0122;
  localparam logic [15:0] FREQ_HI_TH = 16'h01dd;

  localparam logic [2:0] FB_SENSOR_ERR = 3'b001;
  localparam logic [2:0] FB_MULTI_TURN = 3'b011;
  localparam logic [2:0] MODE_POSITION = 3'b011;
  localparam logic SRC_STEP_DIR = 1'b1;

  typedef struct packed {
    logic hall_w;
    logic hall_v;
    logic hall_u;
    logic enable_in;
    logic step_in;
    logic dinp2;
    logic dinp3;
    logic dinp4;
    logic [3:0] dip;
    logic [3:0] rotary;
    logic [4:0] model;
  } ssfv_pins_s;

  typedef struct packed {
    logic [23:0] angle;
    logic [11:0] turns;
    logic [15:0] raw_vel;
    logic [2:0] dev_fault;
  } ssfv_fb_s;

endpackage

/* File: hw/ssfv_status_bank.sv */
/*
  status and fault variable bank of a brushless servo drive.
  assumes pins arrive asynchronous, feedback and fault events come from
  logic on ref_clk, and the register port follows a one-cycle strobe master.
*/
// Contract
// - sixteen-bit extended fault word, bits taken apart from fault codes; heat sink trip sets bit 7 with code 3
// - simultaneous faults are ORed; word holds last active value
// - primary fault code equals LED blink count; codes 2 to 10
// - primary fault codes 11 to 20 cover feedback, comms, option card
// - foldback flag is 1 while current-time overload acts, else 0
// - hall state is W at bit 2, V bit 1, U bit 0
// - step counts on conducting to non-conducting edge in step/dir position mode
// - opto input bit reads 0 when current flows, 1 otherwise
// - logic hardware revision is a four-bit wrapping value
// - base unit code 0 to 31; undefined codes flag configuration error
// - shaft angle holds 24 bits per revolution, low 8 fractional
// - turn count is a signed sample from -2048 to +2047
// - half PWM rate when current above 0.53 peak and frequency below 2.9 Hz
// - base PWM rate when current below 0.32 peak or frequency above 4.77 Hz
// - DIP switch four bits, position 1 lsb, open reads high
// - feedback fault code 001 sensor error, 011 multi-turn, else none
// - raw velocity sample is signed 0.5588 rpm per lsb
// - filtered velocity is angle difference over 26.21 ms
// - logicware version is three bytes: major, minor, suffix
// - rotary switch value 0 to 9
// - heat sink fault when temperature reaches read-only trip value
// - writing 1 to fault clear clears fault logic; 0 does nothing
`timescale 1ns/1ps
module ssfv_status_bank #(
  parameter int VEL_CYCLES = ssfv_pkg::VEL_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire ssfv_pkg::ssfv_pins_s pins,
  input wire ssfv_pkg::ssfv_fb_s fb,
  input wire logic [15:0] ext_fault_evt,
  input wire logic [4:0] fault_code_in,
  input wire logic overload_active,
  input wire logic six_step_in,
  input wire logic [15:0] motor_current,
  input wire logic [15:0] commutation_freq,
  input wire logic [15:0] heatsink_temperature,
  input wire logic [2:0] control_mode_select,
  input wire logic position_command_source,
  output logic motor_power_en,
  output logic pwm_half_rate_flag,
  output logic [4:0] primary_fault_code,
  output logic fault_clear_pulse
);

  logic rst_meta_q;
  logic rst_n;
  ssfv_pkg::ssfv_pins_s pins_meta_q;
  ssfv_pkg::ssfv_pins_s pins_q;
  logic step_prev_q;
  logic [15:0] ext_fault_q;
  logic fault_active_q;
  logic [4:0] fault_code_q;
  logic foldback_q;
  logic half_q;
  logic sw_enable_q;
  logic clr_q;
  logic power_q;
  logic [31:0] step_count_q;
  ssfv_pkg::ssfv_fb_s fb_q;
  logic [23:0] vel_prev_q;
  logic [23:0] filt_vel_q;
  logic [ssfv_pkg::VEL_CNT_W-1:0] vel_cnt_q;
  logic [31:0] rdata_q;
  logic [15:0] fault_evt;
  logic hs_trip;
  logic model_err;
  logic [2:0] hall_state;
  logic step_mode;
  logic step_edge;
  logic vel_tick;
  logic sw_wr;
  logic clr_wr;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // pin synchroniser
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_meta_q <= '1;
      pins_q <= '1;
    end
    else
    begin
      pins_meta_q <= pins;
      pins_q <= pins_meta_q;
    end
  end

  assign hall_state = {pins_q.hall_w, pins_q.hall_v, pins_q.hall_u};
  assign hs_trip = $signed(heatsink_temperature) >= $signed(ssfv_pkg::HS_TRIP_RST);
  assign model_err = !ssfv_pkg::VALID_MODEL_MASK[pins_q.model];
  assign sw_wr = reg_wr && (reg_addr == ssfv_pkg::REG_SW_ENABLE);
  assign clr_wr = reg_wr && (reg_addr == ssfv_pkg::REG_FAULT_CLEAR) && reg_wdata[0];

  always_comb
  begin
    fault_evt = ext_fault_evt;
    fault_evt[ssfv_pkg::EXT_BIT_OVER_TEMP] = ext_fault_evt[ssfv_pkg::EXT_BIT_OVER_TEMP] | hs_trip;
  end

  // extended fault word keeps the last non-empty fault set
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ext_fault_q <= ssfv_pkg::EXT_FAULT_RST;
    else if (fault_evt != 16'h0000)
      ext_fault_q <= fault_evt;
  end

  // primary fault code latch, a new fault beats a clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_active_q <= 1'b0;
      fault_code_q <= ssfv_pkg::FAULT_CODE_RST;
    end
    else if ((!fault_active_q || clr_q) && fault_code_in != 5'h00)
    begin
      fault_active_q <= 1'b1;
      fault_code_q <= fault_code_in;
    end
    else if ((!fault_active_q || clr_q) && hs_trip)
    begin
      fault_active_q <= 1'b1;
      fault_code_q <= ssfv_pkg::FAULT_CODE_DRIVE_TEMP;
    end
    else if (clr_q)
    begin
      fault_active_q <= 1'b0;
      fault_code_q <= ssfv_pkg::FAULT_CODE_RST;
    end
  end

  // software clear pulse
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      clr_q <= 1'b0;
    else
      clr_q <= clr_wr;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      foldback_q <= 1'b0;
    else
      foldback_q <= overload_active;
  end

  // pwm half rate with hysteresis
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      half_q <= 1'b0;
    else if (!half_q && motor_current > ssfv_pkg::CUR_HI_TH
             && commutation_freq < ssfv_pkg::FREQ_LO_TH)
      half_q <= 1'b1;
    else if (half_q && (motor_current < ssfv_pkg::CUR_LO_TH
             || commutation_freq > ssfv_pkg::FREQ_HI_TH))
      half_q <= 1'b0;
  end

  // software power enable, the only host-writable variable besides fault clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sw_enable_q <= ssfv_pkg::SW_ENABLE_RST;
    else if (sw_wr)
      sw_enable_q <= reg_wdata[0];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      power_q <= 1'b0;
    else
      power_q <= sw_enable_q && !pins_q.enable_in;
  end

  // step counting on the release of input current
  assign step_mode = control_mode_select == ssfv_pkg::MODE_POSITION
                     && position_command_source == ssfv_pkg::SRC_STEP_DIR;
  assign step_edge = !step_prev_q && pins_q.step_in;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      step_prev_q <= 1'b1;
    else
      step_prev_q <= pins_q.step_in;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      step_count_q <= 32'h0000_0000;
    else if (step_mode && step_edge)
      step_count_q <= pins_q.dinp4 ? step_count_q + 32'h0000_0001
                                   : step_count_q - 32'h0000_0001;
  end

  // feedback sample capture
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      fb_q <= '0;
    else
      fb_q <= fb;
  end

  // filtered velocity period timer
  assign vel_tick = vel_cnt_q == ssfv_pkg::VEL_CNT_W'(VEL_CYCLES - 1);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      vel_cnt_q <= '0;
    else if (vel_tick)
      vel_cnt_q <= '0;
    else
      vel_cnt_q <= vel_cnt_q + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vel_prev_q <= 24'h00_0000;
      filt_vel_q <= 24'h00_0000;
    end
    else if (vel_tick)
    begin
      vel_prev_q <= fb_q.angle;
      filt_vel_q <= fb_q.angle - vel_prev_q;
    end
  end

  // register read, data stands one cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else if (!reg_rd)
      rdata_q <= 32'h0000_0000;
    else
    begin
      unique case (reg_addr)
        ssfv_pkg::REG_EXT_FAULT: rdata_q <= {16'h0000, ext_fault_q};
        ssfv_pkg::REG_FAULT_CODE: rdata_q <= {26'h000_0000, fault_active_q, fault_code_q};
        ssfv_pkg::REG_STATUS: rdata_q <= {25'h000_0000, power_q, model_err, hs_trip,
                                          six_step_in, half_q, foldback_q, sw_enable_q};
        ssfv_pkg::REG_INPUTS: rdata_q <= {24'h00_0000, pins_q.enable_in, pins_q.step_in,
                                          pins_q.dinp2, pins_q.dinp3, pins_q.dinp4,
                                          hall_state};
        ssfv_pkg::REG_SWITCHES: rdata_q <= {24'h00_0000, pins_q.rotary,
                                            pins_q.dip};
        ssfv_pkg::REG_FB_FAULT: rdata_q <= {27'h000_0000,
                                            fb_q.dev_fault == ssfv_pkg::FB_MULTI_TURN,
                                            fb_q.dev_fault == ssfv_pkg::FB_SENSOR_ERR,
                                            fb_q.dev_fault};
        ssfv_pkg::REG_ANGLE: rdata_q <= {8'h00, fb_q.angle};
        ssfv_pkg::REG_TURNS: rdata_q <= {{20{fb_q.turns[11]}}, fb_q.turns};
        ssfv_pkg::REG_RAW_VEL: rdata_q <= {{16{fb_q.raw_vel[15]}}, fb_q.raw_vel};
        ssfv_pkg::REG_FILT_VEL: rdata_q <= {{8{filt_vel_q[23]}}, filt_vel_q};
        ssfv_pkg::REG_HS_TEMP: rdata_q <= {16'h0000, heatsink_temperature};
        ssfv_pkg::REG_HS_TRIP: rdata_q <= {16'h0000, ssfv_pkg::HS_TRIP_RST};
        ssfv_pkg::REG_IDENT: rdata_q <= {23'h00_0000, pins_q.model,
                                         ssfv_pkg::LOGIC_HW_REV};
        ssfv_pkg::REG_LW_VERSION: rdata_q <= {8'h00, ssfv_pkg::LW_VERSION};
        ssfv_pkg::REG_SW_ENABLE: rdata_q <= {31'h0000_0000, sw_enable_q};
        ssfv_pkg::REG_STEP_COUNT: rdata_q <= step_count_q;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign motor_power_en = power_q;
  assign pwm_half_rate_flag = half_q;
  assign primary_fault_code = fault_code_q;
  assign fault_clear_pulse = clr_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_ext_load;
    (fault_evt != 16'h0000) |=> (ext_fault_q == $past(fault_evt));
  endproperty
  a_ext_load: assert property (p_ext_load) else $error("fault word not loaded");

  property p_ext_hold;
    (fault_evt == 16'h0000) |=> $stable(ext_fault_q);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("fault word lost");

  property p_clear;
    clr_wr ##1 (fault_code_in == 5'h00 && !hs_trip) |=> (fault_code_q == 5'h00);
  endproperty
  a_clear: assert property (p_clear) else $error("fault clear ignored");

  property p_foldback;
    overload_active [*2] |=> foldback_q;
  endproperty
  a_foldback: assert property (p_foldback) else $error("foldback flag wrong");

  property p_half_set;
    (motor_current > ssfv_pkg::CUR_HI_TH && commutation_freq < ssfv_pkg::FREQ_LO_TH)
      |=> pwm_half_rate_flag;
  endproperty
  a_half_set: assert property (p_half_set) else $error("half rate not set");

  property p_half_clr;
    (motor_current < ssfv_pkg::CUR_LO_TH) |=> !pwm_half_rate_flag;
  endproperty
  a_half_clr: assert property (p_half_clr) else $error("half rate not cleared");

  sequence s_release;
    step_mode && !pins_q.step_in ##1 step_mode && pins_q.step_in;
  endsequence

  property p_step_count;
    s_release |=> (step_count_q != $past(step_count_q));
  endproperty
  a_step_count: assert property (p_step_count) else $error("step missed");

  property p_step_none;
    (pins_q.step_in ##1 !pins_q.step_in) |=> $stable(step_count_q);
  endproperty
  a_step_none: assert property (p_step_none) else $error("wrong step edge");

  property p_power;
    !sw_enable_q |=> !motor_power_en;
  endproperty
  a_power: assert property (p_power) else $error("power without enable");

  property p_read_only;
    (reg_wr && reg_addr != ssfv_pkg::REG_SW_ENABLE) |=> $stable(sw_enable_q);
  endproperty
  a_read_only: assert property (p_read_only) else $error("read-only write took");

  property p_hall_read;
    (reg_rd && reg_addr == ssfv_pkg::REG_INPUTS) |=> (reg_rdata[2:0] == $past(hall_state));
  endproperty
  a_hall_read: assert property (p_hall_read) else $error("hall state misread");

endmodule // ssfv_status_bank

/* File: sim/ssfv_host_model.sv */
/*
  register port master standing in for the host setup utility.
  assumes a slave that takes one-cycle strobes and answers reads one cycle later.
*/
`timescale 1ns/1ps
module ssfv_host_model (
  input wire logic ref_clk,
  output logic [4:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial
  begin
    reg_addr = 5'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle write; data and address scrambled once the strobe is gone
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule // ssfv_host_model

/* File: sim/tb.sv */
/*
  self-checking bench for the status and fault variable bank.
  assumes the host model on the register port and a short velocity period.
*/
`timescale 1ns/1ps
module tb;
  typedef struct {
    int unsigned sel;
    logic [4:0] addr;
    logic [31:0] mask;
    logic [31:0] exp;
  } ssfv_row_s;
  localparam logic [15:0] CH = ssfv_pkg::CUR_HI_TH;
  localparam logic [15:0] CL = ssfv_pkg::CUR_LO_TH;
  localparam logic [15:0] FL = ssfv_pkg::FREQ_LO_TH;
  localparam logic [15:0] FH = ssfv_pkg::FREQ_HI_TH;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  ssfv_pkg::ssfv_pins_s pins = '0;
  ssfv_pkg::ssfv_fb_s fb = '0;
  logic [15:0] ext_fault_evt = 16'h0000;
  logic [4:0] fault_code_in = 5'h00;
  logic overload_active = 1'b0;
  logic six_step_in = 1'b0;
  logic [15:0] motor_current = 16'h0000;
  logic [15:0] commutation_freq = 16'h0000;
  logic [15:0] heatsink_temperature = 16'h0100;
  logic [2:0] control_mode_select = 3'b001;
  logic position_command_source = 1'b0;
  logic motor_power_en;
  logic pwm_half_rate_flag;
  logic [4:0] primary_fault_code;
  logic fault_clear_pulse;
  int mismatches = 0;
  int samples_checked = 0;
  logic [31:0] v;
  logic [31:0] v0;
  ssfv_row_s rows [$];
  ssfv_pkg::ssfv_pins_s pset [3] = '{{3'b101, 1'b0, 1'b1, 3'b010, 4'h9, 4'h7, 5'h03},
    {3'b011, 1'b1, 1'b0, 3'b101, 4'h6, 4'h0, 5'h1f},
    {3'b101, 1'b0, 1'b1, 3'b010, 4'h9, 4'h7, 5'h00}};
  ssfv_pkg::ssfv_fb_s fset [3] = '{{24'hab_cdef, 12'h800, 16'h8000, 3'b001},
    {24'h00_ff01, 12'h7ff, 16'h7fff, 3'b011}, {24'h00_0000, 12'h000, 16'h0000, 3'b111}};
  logic [15:0] pc [8] = '{CH + 16'h0001, CL, CL - 16'h0001, CH + 16'h0001, CH,
    CH + 16'h0001, CH + 16'h0001, CH + 16'h0001};
  logic [15:0] pf [8] = '{FL - 16'h0001, FL - 16'h0001, FL - 16'h0001, FL,
    FL - 16'h0001, FL - 16'h0001, FH, FH + 16'h0001};
  logic pe [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  ssfv_status_bank #(
    .VEL_CYCLES(16)
  ) u_dut (
    .ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pins, .fb,
    .ext_fault_evt, .fault_code_in, .overload_active, .six_step_in, .motor_current,
    .commutation_freq, .heatsink_temperature, .control_mode_select,
    .position_command_source, .motor_power_en, .pwm_half_rate_flag, .primary_fault_code,
    .fault_clear_pulse
  );
  ssfv_host_model u_host (
    .ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
  );

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  task automatic rchk(input string n, input logic [4:0] a, input logic [31:0] m,
    input logic [31:0] e);
    logic [31:0] d;
    u_host.rd(a, d);
    chk(n, e, d & m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // step input rises on leaving conduction, then falls back
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge ref_clk) pins.step_in <= 1'b1;
      tick(4);
      @(posedge ref_clk) pins.step_in <= 1'b0;
      tick(4);
    end
  endtask

  initial
  begin
    #400_000;
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    rows.push_back('{0, ssfv_pkg::REG_INPUTS, 32'h0000_00ff, 32'h0000_0055});
    rows.push_back('{1, ssfv_pkg::REG_INPUTS, 32'h0000_00ff, 32'h0000_00ab});
    rows.push_back('{0, ssfv_pkg::REG_SWITCHES, 32'h0000_00ff, 32'h0000_0079});
    rows.push_back('{1, ssfv_pkg::REG_SWITCHES, 32'h0000_00ff, 32'h0000_0006});
    rows.push_back('{0, ssfv_pkg::REG_FB_FAULT, 32'h0000_001f, 32'h0000_0009});
    rows.push_back('{1, ssfv_pkg::REG_FB_FAULT, 32'h0000_001f, 32'h0000_0013});
    rows.push_back('{2, ssfv_pkg::REG_FB_FAULT, 32'h0000_001f, 32'h0000_0007});
    rows.push_back('{0, ssfv_pkg::REG_ANGLE, 32'h00ff_ffff, 32'h00ab_cdef});
    rows.push_back('{1, ssfv_pkg::REG_ANGLE, 32'h00ff_ffff, 32'h0000_ff01});
    rows.push_back('{0, ssfv_pkg::REG_TURNS, 32'h0000_0fff, 32'h0000_0800});
    rows.push_back('{1, ssfv_pkg::REG_TURNS, 32'h0000_0fff, 32'h0000_07ff});
    rows.push_back('{0, ssfv_pkg::REG_RAW_VEL, 32'h0000_ffff, 32'h0000_8000});
    rows.push_back('{1, ssfv_pkg::REG_RAW_VEL, 32'h0000_ffff, 32'h0000_7fff});
    rows.push_back('{0, ssfv_pkg::REG_IDENT, 32'h0000_01ff,
      32'({5'h03, ssfv_pkg::LOGIC_HW_REV})});
    rows.push_back('{1, ssfv_pkg::REG_IDENT, 32'h0000_01ff,
      32'({5'h1f, ssfv_pkg::LOGIC_HW_REV})});
    rows.push_back('{0, ssfv_pkg::REG_STATUS, 32'h0000_0020, 32'h0000_0000});
    rows.push_back('{1, ssfv_pkg::REG_STATUS, 32'h0000_0020, 32'h0000_0020});
    rows.push_back('{2, ssfv_pkg::REG_STATUS, 32'h0000_0020, 32'h0000_0020});
    rows.push_back('{0, ssfv_pkg::REG_HS_TEMP, 32'h0000_ffff, 32'h0000_0100});
    rows.push_back('{0, ssfv_pkg::REG_LW_VERSION, 32'h00ff_ffff,
      32'(ssfv_pkg::LW_VERSION)});
    tick(8);
    @(posedge ref_clk) reset_n <= 1'b1;
    tick(5);
    foreach (rows[i])
    begin
      @(posedge ref_clk) pins <= pset[rows[i].sel];
      fb <= fset[rows[i].sel];
      tick(4);
      rchk("row_read", rows[i].addr, rows[i].mask, rows[i].exp);
      chk("motor_power_en", 32'(!pset[rows[i].sel].enable_in), 32'(motor_power_en));
    end
    rchk("sw_enable_rst", ssfv_pkg::REG_SW_ENABLE, 32'h0000_0001, 32'h0000_0001);
    u_host.wr(ssfv_pkg::REG_SW_ENABLE, 32'h0000_0000);
    tick(1);
    chk("power_off", 32'h0000_0000, 32'(motor_power_en));
    u_host.wr(ssfv_pkg::REG_SW_ENABLE, 32'h0000_0001);
    tick(1);
    chk("power_on", 32'h0000_0001, 32'(motor_power_en));
    u_host.wr(ssfv_pkg::REG_HS_TRIP, 32'h0000_0000);
    rchk("hs_trip", ssfv_pkg::REG_HS_TRIP, 32'h0000_ffff, 32'(ssfv_pkg::HS_TRIP_RST));
    rchk("unmapped", 5'h1f, 32'hffff_ffff, 32'h0000_0000);
    @(posedge ref_clk) ext_fault_evt <= 16'h8100;
    @(posedge ref_clk) ext_fault_evt <= 16'h0000;
    tick(3);
    rchk("ext_word", ssfv_pkg::REG_EXT_FAULT, 32'h0000_ffff, 32'h0000_8100);
    for (int k = 2; k <= 20; k++)
    begin
      @(posedge ref_clk) fault_code_in <= 5'(k);
      @(posedge ref_clk) fault_code_in <= 5'h01;
      #1;
      chk("fault_code", 32'(k), 32'(primary_fault_code));
      @(posedge ref_clk) fault_code_in <= 5'h00;
      #1;
      chk("fault_kept", 32'(k), 32'(primary_fault_code));
      rchk("fault_reg", ssfv_pkg::REG_FAULT_CODE, 32'h0000_003f, 32'h20 | 32'(k));
      u_host.wr(ssfv_pkg::REG_FAULT_CLEAR, 32'h0000_0001);
      chk("clear_pulse", 32'h0000_0001, 32'(fault_clear_pulse));
      tick(1);
      chk("cleared", 32'h0000_0000, 32'(primary_fault_code));
    end
    @(posedge ref_clk) heatsink_temperature <= ssfv_pkg::HS_TRIP_RST - 16'h0001;
    tick(4);
    chk("hs_below", 32'h0000_0000, 32'(primary_fault_code));
    u_host.wr(ssfv_pkg::REG_FAULT_CLEAR, 32'h0000_0000);
    chk("no_pulse", 32'h0000_0000, 32'(fault_clear_pulse));
    @(posedge ref_clk) heatsink_temperature <= ssfv_pkg::HS_TRIP_RST;
    tick(4);
    chk("hs_trip_code", 32'(ssfv_pkg::FAULT_CODE_DRIVE_TEMP), 32'(primary_fault_code));
    rchk("hs_ext_bit", ssfv_pkg::REG_EXT_FAULT, 32'h0000_0080, 32'h0000_0080);
    @(posedge ref_clk) heatsink_temperature <= 16'h0100;
    tick(2);
    u_host.wr(ssfv_pkg::REG_FAULT_CLEAR, 32'h0000_0001);
    @(posedge ref_clk) overload_active <= 1'b1;
    six_step_in <= 1'b1;
    tick(3);
    rchk("foldback_on", ssfv_pkg::REG_STATUS, 32'h0000_000a, 32'h0000_000a);
    @(posedge ref_clk) overload_active <= 1'b0;
    six_step_in <= 1'b0;
    tick(3);
    rchk("foldback_off", ssfv_pkg::REG_STATUS, 32'h0000_000a, 32'h0000_0000);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk) motor_current <= pc[i];
      commutation_freq <= pf[i];
      tick(2);
      chk("pwm_half", 32'(pe[i]), 32'(pwm_half_rate_flag));
    end
    @(posedge ref_clk) control_mode_select <= ssfv_pkg::MODE_POSITION;
    position_command_source <= ssfv_pkg::SRC_STEP_DIR;
    pins.dinp4 <= 1'b1;
    pins.step_in <= 1'b0;
    tick(4);
    u_host.rd(ssfv_pkg::REG_STEP_COUNT, v0);
    pulses(3);
    rchk("steps", ssfv_pkg::REG_STEP_COUNT, 32'h0000_ffff, (v0 + 32'd3) & 32'h0000_ffff);
    @(posedge ref_clk) position_command_source <= 1'b0;
    pulses(2);
    @(posedge ref_clk) control_mode_select <= 3'b001;
    position_command_source <= ssfv_pkg::SRC_STEP_DIR;
    pulses(2);
    rchk("no_steps", ssfv_pkg::REG_STEP_COUNT, 32'h0000_ffff, (v0 + 32'd3) & 32'h0000_ffff);
    @(posedge ref_clk) fb.angle <= 24'h10_0000;
    tick(40);
    @(posedge ref_clk) fb.angle <= 24'h10_0064;
    v = 32'h0000_0000;
    for (int i = 0; i < 40 && v == 32'h0000_0000; i++)
    begin
      u_host.rd(ssfv_pkg::REG_FILT_VEL, v);
      v = v & 32'h00ff_ffff;
    end
    chk("filt_vel", 32'h0000_0064, v);
    tick(40);
    rchk("filt_still", ssfv_pkg::REG_FILT_VEL, 32'h00ff_ffff, 32'h0000_0000);
    u_host.wr(ssfv_pkg::REG_SW_ENABLE, 32'h0000_0000);
    @(posedge ref_clk) reset_n <= 1'b0;
    #1;
    chk("rst_power", 32'h0000_0000, 32'(motor_power_en));
    tick(8);
    @(posedge ref_clk) reset_n <= 1'b1;
    tick(5);
    rchk("sw_enable_again", ssfv_pkg::REG_SW_ENABLE, 32'h0000_0001, 32'h0000_0001);
    rchk("ext_rst", ssfv_pkg::REG_EXT_FAULT, 32'h0000_ffff, 32'(ssfv_pkg::EXT_FAULT_RST));
    chk("power_back", 32'h0000_0001, 32'(motor_power_en));
    tally_and_finish();
  end
endmodule // tb
